// >>> design/usb_redriver_ctrl_pkg.sv
package usb_redriver_ctrl_pkg;
  // ------------------------------------------------------------
  // register offsets, fields and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] REG_GEN_CTRL = 8'h0A;
  localparam logic [7:0] REG_DISP_CTRL = 8'h13;
  localparam logic [7:0] REG_UP_EQ = 8'h21;
  localparam logic [7:0] REG_USB_CTRL = 8'h22;
  localparam int GEN_OVR_BIT = 4;
  localparam int DISP_SNOOP_OFF_BIT = 7;
  localparam int DISP_AUX_LSB = 4;
  localparam int USB_CM_BIT = 7;
  localparam int USB_LOWFREQ_SIGNAL_EQ_APPLY_BIT = 6;
  localparam int USB_DEBOUNCE_BIT = 5;
  localparam int USB_DET_OFF_BIT = 4;
  localparam int USB_PERIOD_LSB = 2;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  // edges after reset release until the synchronisers hold the strap pins
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // ------------------------------------------------------------
  // slave address from the two address straps
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_UPPER = 5'h04;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_FLOAT = 2'h2;
  // ------------------------------------------------------------
  // field encodings
  // ------------------------------------------------------------
  localparam logic [1:0] CM_BY_FSM = 2'h0;
  localparam logic [1:0] CM_FORCE_DFP = 2'h1;
  localparam logic [1:0] CM_FORCE_UFP = 2'h2;
  localparam logic [1:0] CM_OFF = 2'h3;
  localparam logic [1:0] AUX_AUTO = 2'h0;
  localparam logic [1:0] AUX_STRAIGHT = 2'h1;
  localparam logic [1:0] AUX_CROSS = 2'h2;
  localparam logic [1:0] PERIOD_8MS = 2'h0;
  localparam logic [1:0] PERIOD_12MS = 2'h1;
  localparam logic [3:0] ALL_LANES = 4'hF;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_US = 200;
  localparam int DET_SHORT_MS = 8;
  localparam int DET_LONG_MS = 12;
  localparam int CNT_W = 21;
  localparam logic [20:0] DEBOUNCE_CYCLES = 21'(DEBOUNCE_US * CLK_MHZ);
  localparam logic [20:0] DET_SHORT_CYCLES = 21'(DET_SHORT_MS * 1000 * CLK_MHZ);
  localparam logic [20:0] DET_LONG_CYCLES = 21'(DET_LONG_MS * 1000 * CLK_MHZ);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ------------------------------------------------------------
  // serial slave states
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ACK = 6'b000100,
    ST_WR = 6'b001000,
    ST_RD = 6'b010000,
    ST_RACK = 6'b100000
  } ser_state_type;
endpackage

// >>> design/usb_redriver_ctrl_regs.sv
`timescale 1ns/1ps
// What this block does
// - Override clear: upstream eq field reads back the latched strap value.
// - Override set in serial config mode: upstream eq level follows last software write.
// - Read-only status bit 7 shows compliance mode active.
// - Lowfreq_signal_eq_apply bit 0 forces receiver eq zero during LFPS; 1 applies settings.
// - Debounce bit set: LFPS must last 200 us before low-power exit.
// - Detect-off bit set: no receiver detect while in U2/U3.
// - Receiver detect repeats every 8 ms (00) or 12 ms (01).
// - Compliance select: fsm, force downstream, force upstream, or disabled.
// - Both address straps floating gives slave address 0x12.
// - Serial config mode lets the upstream receiver eq be set by register.
// - Main-link lane polarity passes through uncorrected.
// - Strap configuration enables all four display lanes.
// - Aux route 00 follows path and orientation; 11 leaves it open.
// - Lane disable bits act only while snooping is disabled.
module usb_redriver_ctrl_regs #(
  parameter logic [20:0] DEBOUNCE_CYC = usb_redriver_ctrl_pkg::DEBOUNCE_CYCLES,
  parameter logic [20:0] DET_SHORT_CYC = usb_redriver_ctrl_pkg::DET_SHORT_CYCLES,
  parameter logic [20:0] DET_LONG_CYC = usb_redriver_ctrl_pkg::DET_LONG_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic i2c_mode_i,
  input wire logic [1:0] upstream_eq_strap_pins_i,
  input wire logic [1:0] display_eq_addr_hi_strap_i,
  input wire logic [1:0] upstream_eq_addr_lo_strap_i,
  input wire logic fsm_compliance_i,
  input wire logic lfps_present_i,
  input wire logic in_low_power_i,
  input wire logic display_path_select_i,
  input wire logic orientation_select_i,
  input wire logic [3:0] snoop_lane_en_i,
  output logic [3:0] upstream_eq_level_o,
  output logic eq_force_zero_o,
  output logic compliance_dfp_o,
  output logic compliance_ufp_o,
  output logic low_power_exit_o,
  output logic rx_detect_o,
  output logic aux_straight_o,
  output logic aux_cross_o,
  output logic [3:0] display_lane_en_o,
  output logic lane_invert_o
);
  import usb_redriver_ctrl_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers and strap latch
  // ------------------------------------------------------------
  logic [8:0] pin_s1_q, pin_s2_q;
  logic scl_q, sda_q;
  logic strap_done_q;
  logic [1:0] strap_wait_q;
  logic [3:0] strap_eq_q;
  logic [6:0] dev_addr_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 9'h1FF;
      pin_s2_q <= 9'h1FF;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      pin_s1_q <= {i2c_mode_i, upstream_eq_strap_pins_i, display_eq_addr_hi_strap_i,
                   upstream_eq_addr_lo_strap_i, scl_i, sda_i};
      pin_s2_q <= pin_s1_q;
      scl_q <= pin_s2_q[1];
      sda_q <= pin_s2_q[0];
    end
  end

  wire scl_s = pin_s2_q[1];
  wire sda_s = pin_s2_q[0];
  wire i2c_mode_s = pin_s2_q[8];
  wire [1:0] a1_lvl = pin_s2_q[5:4];
  wire [1:0] a0_lvl = pin_s2_q[3:2];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_q <= 1'b0;
      strap_wait_q <= 2'h0;
      strap_eq_q <= RST_NIBBLE;
      dev_addr_q <= {ADDR_UPPER, 2'h0};
    end else if (!strap_done_q) begin
      // latching earlier would capture the synchronisers' reset value
      if (strap_wait_q == STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
        strap_eq_q <= {2'h0, pin_s2_q[7:6]};
        dev_addr_q <= {ADDR_UPPER, a1_lvl != LVL_LOW, a0_lvl == LVL_HIGH};
      end else begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // serial slave: pointer byte then auto-incremented data
  // ------------------------------------------------------------
  wire start_c = scl_s && scl_q && sda_q && !sda_s;
  wire stop_c = scl_s && scl_q && !sda_q && sda_s;
  wire rise_c = scl_s && !scl_q;
  wire fall_c = !scl_s && scl_q;

  ser_state_type state_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q, ptr_q, rdata;
  logic rw_q, first_q, wr_stb_q;
  logic [7:0] wr_addr_q, wr_data_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_c) begin
        state_q <= ST_ADDR;
        bitcnt_q <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        state_q <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_WR: begin
            if (rise_c) begin
              shift_q <= {shift_q[6:0], sda_s};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (fall_c && bitcnt_q == BITS_PER_BYTE) begin
              sda_oe_o <= 1'b1;
              state_q <= ST_ACK;
              if (state_q == ST_ADDR) begin
                if (shift_q[7:1] == dev_addr_q) begin
                  rw_q <= shift_q[0];
                  first_q <= !shift_q[0];
                end else begin
                  sda_oe_o <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end else if (first_q) begin
                ptr_q <= shift_q;
                first_q <= 1'b0;
              end else begin
                wr_stb_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          ST_ACK, ST_RACK: begin
            if (rise_c && state_q == ST_RACK && sda_s) begin
              state_q <= ST_IDLE;
            end else if (fall_c) begin
              bitcnt_q <= 4'h0;
              if (rw_q) begin
                state_q <= ST_RD;
                shift_q <= rdata;
                ptr_q <= ptr_q + 8'h01;
                sda_oe_o <= !rdata[7];
              end else begin
                state_q <= ST_WR;
                sda_oe_o <= 1'b0;
              end
            end
          end
          ST_RD: begin
            if (rise_c) begin
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (fall_c) begin
              if (bitcnt_q == BITS_PER_BYTE) begin
                state_q <= ST_RACK;
                sda_oe_o <= 1'b0;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe_o <= !shift_q[6];
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic ovr_q, snoop_off_q, compliance_active_flag_q;
  logic [1:0] aux_force_q;
  logic [3:0] lane_off_q, up_eq_sw_q;
  logic [6:0] usb_ctrl_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovr_q <= 1'b0;
      snoop_off_q <= 1'b0;
      aux_force_q <= 2'h0;
      lane_off_q <= RST_NIBBLE;
      up_eq_sw_q <= RST_NIBBLE;
      usb_ctrl_q <= RST_REG[6:0];
    end else if (wr_stb_q) begin
      case (wr_addr_q)
        REG_GEN_CTRL: ovr_q <= wr_data_q[GEN_OVR_BIT];
        REG_DISP_CTRL: begin
          snoop_off_q <= wr_data_q[DISP_SNOOP_OFF_BIT];
          aux_force_q <= wr_data_q[DISP_AUX_LSB +: 2];
          lane_off_q <= wr_data_q[3:0];
        end
        REG_UP_EQ: up_eq_sw_q <= wr_data_q[3:0];
        REG_USB_CTRL: usb_ctrl_q <= wr_data_q[6:0];
        default: ;
      endcase
    end
  end

  wire ovr_eff = i2c_mode_s && ovr_q;
  wire [3:0] eq_sel = ovr_eff ? up_eq_sw_q : strap_eq_q;
  wire [1:0] cm_sel = usb_ctrl_q[1:0];
  wire [1:0] period_sel = usb_ctrl_q[USB_PERIOD_LSB +: 2];
  wire lfps_zero = lfps_present_i && !usb_ctrl_q[USB_LOWFREQ_SIGNAL_EQ_APPLY_BIT];

  always_comb begin
    rdata = 8'h00;
    case (ptr_q)
      REG_GEN_CTRL: rdata[GEN_OVR_BIT] = ovr_q;
      REG_DISP_CTRL: rdata = {snoop_off_q, 1'b0, aux_force_q, lane_off_q};
      REG_UP_EQ: rdata = {4'h0, eq_sel};
      REG_USB_CTRL: rdata = {compliance_active_flag_q, usb_ctrl_q};
      default: rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // equaliser, compliance, aux and lane outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      upstream_eq_level_o <= RST_NIBBLE;
      eq_force_zero_o <= 1'b0;
      compliance_active_flag_q <= 1'b0;
      compliance_dfp_o <= 1'b0;
      compliance_ufp_o <= 1'b0;
      aux_straight_o <= 1'b0;
      aux_cross_o <= 1'b0;
      display_lane_en_o <= RST_NIBBLE;
      lane_invert_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      upstream_eq_level_o <= lfps_zero ? 4'h0 : eq_sel;
      eq_force_zero_o <= lfps_zero;
      compliance_active_flag_q <= (cm_sel == CM_BY_FSM) ? fsm_compliance_i : (cm_sel != CM_OFF);
      compliance_dfp_o <= cm_sel == CM_FORCE_DFP;
      compliance_ufp_o <= cm_sel == CM_FORCE_UFP;
      case (aux_force_q)
        AUX_AUTO: begin
          aux_straight_o <= display_path_select_i && !orientation_select_i;
          aux_cross_o <= display_path_select_i && orientation_select_i;
        end
        AUX_STRAIGHT: begin
          aux_straight_o <= 1'b1;
          aux_cross_o <= 1'b0;
        end
        AUX_CROSS: begin
          aux_straight_o <= 1'b0;
          aux_cross_o <= 1'b1;
        end
        default: begin
          aux_straight_o <= 1'b0;
          aux_cross_o <= 1'b0;
        end
      endcase
      if (!i2c_mode_s) begin
        display_lane_en_o <= ALL_LANES;
      end else if (snoop_off_q) begin
        display_lane_en_o <= ~lane_off_q;
      end else begin
        display_lane_en_o <= snoop_lane_en_i;
      end
      lane_invert_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // low-power exit debounce and receiver detect timer
  // ------------------------------------------------------------
  logic [20:0] deb_cnt_q, det_cnt_q;
  logic exited_q;
  wire [20:0] period = (period_sel == PERIOD_8MS) ? DET_SHORT_CYC : DET_LONG_CYC;
  wire deb_on = usb_ctrl_q[USB_DEBOUNCE_BIT];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      deb_cnt_q <= 21'h0;
      exited_q <= 1'b0;
      low_power_exit_o <= 1'b0;
    end else begin
      low_power_exit_o <= 1'b0;
      if (!(lfps_present_i && in_low_power_i)) begin
        deb_cnt_q <= 21'h0;
        exited_q <= 1'b0;
      end else if (!exited_q) begin
        if (!deb_on || deb_cnt_q == DEBOUNCE_CYC - 21'h1) begin
          low_power_exit_o <= 1'b1;
          exited_q <= 1'b1;
        end else begin
          deb_cnt_q <= deb_cnt_q + 21'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_cnt_q <= 21'h0;
      rx_detect_o <= 1'b0;
    end else begin
      rx_detect_o <= 1'b0;
      if (det_cnt_q >= period - 21'h1) begin
        det_cnt_q <= 21'h0;
        rx_detect_o <= !(in_low_power_i && usb_ctrl_q[USB_DET_OFF_BIT]);
      end else begin
        det_cnt_q <= det_cnt_q + 21'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_eq_strap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (strap_done_q && !ovr_eff && !lfps_zero) |=> upstream_eq_level_o == strap_eq_q)
    else $error("eq level does not follow strap");
  a_eq_soft: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ovr_eff && !lfps_zero) |=> upstream_eq_level_o == $past(up_eq_sw_q))
    else $error("eq level does not follow software");
  a_cm_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cm_sel == CM_OFF) [*2] |-> !compliance_active_flag_q && !compliance_dfp_o && !compliance_ufp_o)
    else $error("compliance flag set while disabled");
  a_lfps_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lfps_zero |=> upstream_eq_level_o == 4'h0 && eq_force_zero_o)
    else $error("eq not zero during lfps");
  a_debounce_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (low_power_exit_o && $past(deb_on)) |-> $past(deb_cnt_q) == DEBOUNCE_CYC - 21'h1)
    else $error("low power exit before debounce");
  a_rxdet_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rx_detect_o |-> !$past(in_low_power_i && usb_ctrl_q[USB_DET_OFF_BIT]))
    else $error("detect issued in low power");
  a_rxdet_period: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rx_detect_o |-> $past(det_cnt_q) >= $past(period) - 21'h1)
    else $error("detect period wrong");
  a_force_dfp: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cm_sel == CM_FORCE_DFP) |=> compliance_dfp_o && compliance_active_flag_q && !compliance_ufp_o)
    else $error("downstream compliance not forced");
  a_addr_miss: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_q == ST_ADDR && fall_c && !start_c && !stop_c && bitcnt_q == BITS_PER_BYTE
     && shift_q[7:1] != dev_addr_q) |=> !sda_oe_o && state_q == ST_IDLE)
    else $error("acked foreign address");
  a_lanes_strap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !i2c_mode_s |=> display_lane_en_o == ALL_LANES)
    else $error("lanes not all on in strap mode");
  a_aux_open: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (aux_force_q == 2'h3) |=> !aux_straight_o && !aux_cross_o)
    else $error("aux path not open");
  a_lane_snoop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (i2c_mode_s && !snoop_off_q) |=> display_lane_en_o == $past(snoop_lane_en_i))
    else $error("lane bits acted while snooping");
  c_reg_write: cover property (@(posedge clk_i) disable iff (!nrst_i) wr_stb_q);
  c_lp_exit: cover property (@(posedge clk_i) disable iff (!nrst_i) low_power_exit_o && deb_on);
  c_rx_detect: cover property (@(posedge clk_i) disable iff (!nrst_i) rx_detect_o);
endmodule

// >>> tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  localparam int Q = 8;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic hold();
    repeat (Q) @(negedge clk_i);
  endtask
  // --------------------------------------------------------------
  // framing: start or repeated start, stop; scl left low after start
  // --------------------------------------------------------------
  task automatic start();
    sda_oe_o = 1'b0;
    hold();
    scl_o = 1'b1;
    hold();
    sda_oe_o = 1'b1;
    hold();
    scl_o = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    hold();
    scl_o = 1'b1;
    hold();
    sda_oe_o = 1'b0;
    hold();
  endtask
  // --------------------------------------------------------------
  // bits and bytes, msb first; data moves only while scl is low
  // --------------------------------------------------------------
  task automatic bit_io(input logic b, output logic seen);
    sda_oe_o = ~b;
    hold();
    scl_o = 1'b1;
    hold();
    seen = sda_i;
    scl_o = 1'b0;
    hold();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // last high gives the nack that ends a read
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import usb_redriver_ctrl_pkg::*;
  localparam logic [6:0] DEV = 7'h12;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic i2c_mode = 1'b1;
  logic fsm_cm = 1'b0;
  logic lfps = 1'b0;
  logic low_pwr = 1'b0;
  logic [3:0] snoop_lanes = 4'h6;
  logic path_sel = 1'b0;
  logic orient = 1'b1;
  logic m_scl, m_oe, d_sda, d_oe, force0, dfp, ufp, lp_exit, rxdet, aux_s, aux_c, inv;
  logic [3:0] eq_lvl, lanes;
  wire sda = (d_oe ? d_sda : 1'b1) & ~m_oe;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #5 clk_i = ~clk_i;
  i2c_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(m_scl), .sda_oe_o(m_oe));
  usb_redriver_ctrl_regs #(.DEBOUNCE_CYC(21'd20), .DET_SHORT_CYC(21'd40),
    .DET_LONG_CYC(21'd60)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(m_scl), .sda_i(sda), .sda_o(d_sda),
    .sda_oe_o(d_oe), .i2c_mode_i(i2c_mode), .upstream_eq_strap_pins_i(2'h2),
    .display_eq_addr_hi_strap_i(LVL_FLOAT), .upstream_eq_addr_lo_strap_i(LVL_FLOAT),
    .fsm_compliance_i(fsm_cm), .lfps_present_i(lfps), .in_low_power_i(low_pwr),
    .display_path_select_i(path_sel), .orientation_select_i(orient), .snoop_lane_en_i(snoop_lanes),
    .upstream_eq_level_o(eq_lvl), .eq_force_zero_o(force0), .compliance_dfp_o(dfp),
    .compliance_ufp_o(ufp), .low_power_exit_o(lp_exit), .rx_detect_o(rxdet),
    .aux_straight_o(aux_s), .aux_cross_o(aux_c), .display_lane_en_o(lanes),
    .lane_invert_o(inv));
  // --------------------------------------------------------------
  // compare, report, end of run
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      test_done();
    end
  end
  // --------------------------------------------------------------
  // register access over the serial bus
  // --------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    m.start();
    m.put_byte({DEV, 1'b0}, k0);
    m.put_byte(a, k1);
    m.put_byte(d, k2);
    m.stop();
    check("write acks", 8'h07, {5'h00, k0, k1, k2});
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic k0, k1, k2;
    logic [7:0] d;
    m.start();
    m.put_byte({DEV, 1'b0}, k0);
    m.put_byte(a, k1);
    m.start();
    m.put_byte({DEV, 1'b1}, k2);
    m.get_byte(1'b1, d);
    m.stop();
    check("read acks", 8'h07, {5'h00, k0, k1, k2});
    check(what, exp, d);
  endtask
  // sel 0 counts detect pulses, sel 1 exit pulses, over cnt cycles
  task automatic pulses(input logic sel, input int cnt, output int p);
    p = 0;
    repeat (cnt) begin
      @(negedge clk_i);
      if ((sel ? lp_exit : rxdet) === 1'b1)
        p++;
    end
  endtask
  task automatic rx_gap(input logic [7:0] exp);
    int k;
    k = 0;
    while (rxdet !== 1'b1 && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (rxdet !== 1'b1 && k < 300);
    check("detect gap", exp, k[7:0]);
  endtask
  task automatic exit_time(output int k);
    lfps = 1'b1;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (lp_exit !== 1'b1 && k < 100);
    lfps = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic k;
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    m.start();
    m.put_byte({7'h13, 1'b0}, k);
    m.stop();
    check("foreign address ack", 8'h00, {7'h00, k});
    rd_chk("usb ctrl reset", REG_USB_CTRL, 8'h00);
    rd_chk("disp ctrl reset", REG_DISP_CTRL, 8'h00);
    rd_chk("eq from straps", REG_UP_EQ, 8'h02);
    reg_wr(REG_UP_EQ, 8'hF5);
    rd_chk("eq still straps", REG_UP_EQ, 8'h02);
    reg_wr(REG_GEN_CTRL, 8'h10);
    rd_chk("override bit", REG_GEN_CTRL, 8'h10);
    rd_chk("eq software", REG_UP_EQ, 8'h05);
    check("eq level out", 8'h05, {4'h0, eq_lvl});
    reg_wr(REG_UP_EQ, 8'h08);
    check("eq level new", 8'h08, {4'h0, eq_lvl});
    reg_wr(REG_GEN_CTRL, 8'h00);
    check("eq level strap", 8'h02, {4'h0, eq_lvl});
    fsm_cm = 1'b1;
    rd_chk("compliance active", REG_USB_CTRL, 8'h80);
    reg_wr(REG_USB_CTRL, 8'h83);
    rd_chk("compliance off", REG_USB_CTRL, 8'h03);
    for (int c = 0; c < 4; c++) begin
      reg_wr(REG_USB_CTRL, 8'(c));
      check("compliance force", {6'h00, c == 1, c == 2}, {6'h00, dfp, ufp});
    end
    fsm_cm = 1'b0;
    reg_wr(REG_USB_CTRL, 8'h00);
    rx_gap(8'd40);
    reg_wr(REG_USB_CTRL, 8'h04);
    rx_gap(8'd60);
    reg_wr(REG_USB_CTRL, 8'h08);
    rx_gap(8'd60);
    low_pwr = 1'b1;
    reg_wr(REG_USB_CTRL, 8'h00);
    rx_gap(8'd40);
    reg_wr(REG_USB_CTRL, 8'h10);
    pulses(1'b0, 130, n);
    check("detect in low power", 8'h00, n[7:0]);
    exit_time(n);
    check("fast exit", 8'h01, {7'h00, n <= 3});
    reg_wr(REG_USB_CTRL, 8'h30);
    exit_time(n);
    check("debounced exit", 8'h01, {7'h00, n >= 20 && n <= 23});
    lfps = 1'b1;
    repeat (10) @(negedge clk_i);
    lfps = 1'b0;
    pulses(1'b1, 40, n);
    check("short burst exit", 8'h00, n[7:0]);
    lfps = 1'b1;
    repeat (4) @(negedge clk_i);
    check("eq forced zero", 8'h01, {7'h00, force0});
    reg_wr(REG_USB_CTRL, 8'h70);
    check("eq applied", 8'h00, {7'h00, force0});
    lfps = 1'b0;
    low_pwr = 1'b0;
    reg_wr(REG_USB_CTRL, 8'h00);
    check("eq no lfps", 8'h00, {7'h00, force0});
    reg_wr(REG_DISP_CTRL, 8'hFF);
    rd_chk("disp reserved", REG_DISP_CTRL, 8'hBF);
    check("lanes all off", 8'h00, {4'h0, lanes});
    reg_wr(REG_DISP_CTRL, 8'h85);
    check("lanes by register", 8'h0A, {4'h0, lanes});
    reg_wr(REG_DISP_CTRL, 8'h05);
    check("lanes by snoop", 8'h06, {4'h0, lanes});
    reg_wr(REG_DISP_CTRL, 8'h90);
    check("aux normal", 8'h02, {6'h00, aux_s, aux_c});
    reg_wr(REG_DISP_CTRL, 8'hA0);
    check("aux flipped", 8'h01, {6'h00, aux_s, aux_c});
    reg_wr(REG_DISP_CTRL, 8'hB0);
    check("aux open", 8'h00, {6'h00, aux_s, aux_c});
    reg_wr(REG_DISP_CTRL, 8'h80);
    check("aux auto no path", 8'h00, {6'h00, aux_s, aux_c});
    path_sel = 1'b1;
    repeat (3) @(negedge clk_i);
    check("aux auto flipped", 8'h01, {6'h00, aux_s, aux_c});
    orient = 1'b0;
    repeat (3) @(negedge clk_i);
    check("aux auto normal", 8'h02, {6'h00, aux_s, aux_c});
    reg_wr(8'h30, 8'hFF);
    rd_chk("unmapped", 8'h30, 8'h00);
    check("no lane inversion", 8'h00, {7'h00, inv});
    i2c_mode = 1'b0;
    repeat (10) @(negedge clk_i);
    check("strap mode lanes", 8'h0F, {4'h0, lanes});
    check("eq strap mode", 8'h02, {4'h0, eq_lvl});
    test_done();
  end
endmodule
